// *** design/lds_pkg.sv ***
// Purpose: constants for the led digit scan and blanking block
// Assumes: 25 MHz system clock, display refresh derived from it
// Notes: slot and gap counts are derived from times in ns
package lds_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DIGITS = 8;
  localparam int SLOT_TIME_NS = 244000;
  localparam int GAP_TIME_NS = 6000;
  localparam int REFRESH_HZ = 500;
  // least times round up to whole cycles
  localparam int SLOT_CYCLES =
    (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES =
    (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_DIV = 4;
  localparam logic [3:0] MODE_FREQ = 4'h0;
  localparam logic [3:0] MODE_PERIOD = 4'h1;
  localparam logic [3:0] MODE_RATIO = 4'h2;
  localparam logic [3:0] MODE_INTERVAL = 4'h3;
  localparam logic [3:0] MODE_UNIT = 4'h4;
  localparam logic [3:0] DIGIT_EIGHT = 4'h8;
  localparam logic [2:0] DP_BASE_DEFAULT = 3'h1;
  localparam logic [2:0] DP_BASE_RATIO = 3'h0;
  localparam logic [2:0] TOP_INDEX = 3'h7;
  localparam logic [6:0] SEG_OFF = 7'h00;
  localparam logic [6:0] SEG_BLANK_ALL = 7'h00;
  typedef enum logic [0:0] {
    LDS_SLOT = 1'b0,
    LDS_GAP = 1'b1
  } lds_phase_type;
endpackage

// *** design/lds_seg_decode.sv ***
// Purpose: bcd digit to seven segment pattern, segments g..a
// Assumes: common cathode, segment high lights
// Notes: codes above nine show dark
`timescale 1ns/100ps
module lds_seg_decode (
  input wire logic [3:0] bcd,
  output logic [6:0] seg
);
  always_comb begin
    unique case (bcd)
      4'h0: seg = 7'h3F;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5B;
      4'h3: seg = 7'h4F;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6D;
      4'h6: seg = 7'h7D;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7F;
      4'h9: seg = 7'h6F;
      default: seg = 7'h00;
    endcase
  end
endmodule

// *** design/lds_scan.sv ***
// Purpose: eight digit multiplexed led scanner with blanking
// Assumes: inputs synchronous to clk; common cathode display
// Notes: slow_timebase stretches slot and gap by four
`timescale 1ns/100ps
module lds_scan
  import lds_pkg::*;
#(
  parameter int SLOT_CNT = SLOT_CYCLES,
  parameter int GAP_CNT = GAP_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [31:0] digit_values,
  input wire logic [3:0] meas_mode,
  input wire logic [1:0] range_sel,
  input wire logic main_overflow,
  input wire logic any_overflow,
  input wire logic display_test,
  input wire logic display_off,
  input wire logic slow_timebase,
  output logic [7:0] digit_drive,
  output logic [6:0] seg_drive,
  output logic dp_drive,
  output logic least_digit_drive,
  output logic top_digit_drive
);
  lds_phase_type phase_reg;
  logic [17:0] count_reg;
  logic [2:0] digit_reg;
  logic [7:0] digit_drive_reg;
  logic [6:0] seg_reg;
  logic dp_reg;
  logic [17:0] slot_len;
  logic [17:0] gap_len;
  logic phase_done;
  logic [2:0] dp_pos;
  logic [7:0] nonzero;
  logic [7:0] show;
  logic [3:0] cur_bcd;
  logic [3:0] shown_bcd;
  logic [6:0] dec_seg;
  logic cur_show;
  logic cur_dp;

  assign slot_len = slow_timebase ? 18'(SLOT_CNT * SLOW_DIV)
                                  : 18'(SLOT_CNT);
  assign gap_len = slow_timebase ? 18'(GAP_CNT * SLOW_DIV)
                                 : 18'(GAP_CNT);
  // compare with >= so a timebase switch mid-phase cannot run past the end
  assign phase_done = (phase_reg == LDS_SLOT)
                      ? (count_reg >= slot_len - 18'h0001)
                      : (count_reg >= gap_len - 18'h0001);

  // decimal point by mode and range
  assign dp_pos = (meas_mode == MODE_UNIT) ? DP_BASE_RATIO :
                  (meas_mode == MODE_RATIO)
                  ? 3'(DP_BASE_RATIO + {1'b0, range_sel})
                  : 3'(DP_BASE_DEFAULT + {1'b0, range_sel});

  // blank zeros left of first nonzero or point
  genvar gi;
  generate
    for (gi = 0; gi < DIGITS; gi++) begin : g_blank
      assign nonzero[gi] = digit_values[gi*4 +: 4] != 4'h0;
      if (gi == DIGITS - 1) begin : g_top
        assign show[gi] = nonzero[gi] || (dp_pos == 3'(gi))
                          || main_overflow || display_test;
      end else begin : g_rest
        // at or right of point always shown
        assign show[gi] = nonzero[gi] || show[gi+1]
                          || (dp_pos >= 3'(gi)) || main_overflow
                          || display_test;
      end
    end
  endgenerate

  assign cur_bcd = digit_values[digit_reg*4 +: 4];
  assign cur_show = show[digit_reg];
  assign shown_bcd = display_test ? DIGIT_EIGHT : cur_bcd;
  assign cur_dp = display_test || (digit_reg == dp_pos)
                  || (any_overflow && digit_reg == TOP_INDEX);

  lds_seg_decode u_dec (
    .bcd(shown_bcd),
    .seg(dec_seg)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= LDS_GAP;
      count_reg <= 18'h0000;
      digit_reg <= 3'h0;
    end else if (clk_en) begin
      if (phase_done) begin
        count_reg <= 18'h0000;
        phase_reg <= (phase_reg == LDS_SLOT) ? LDS_GAP : LDS_SLOT;
        if (phase_reg == LDS_SLOT) begin
          digit_reg <= digit_reg + 3'h1;
        end
      end else begin
        count_reg <= count_reg + 18'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      digit_drive_reg <= 8'h00;
      seg_reg <= SEG_OFF;
      dp_reg <= 1'b0;
    end else if (clk_en) begin
      if (phase_reg == LDS_SLOT && !display_off) begin
        digit_drive_reg <= 8'h01 << digit_reg;
        seg_reg <= cur_show ? dec_seg : SEG_BLANK_ALL;
        dp_reg <= cur_dp;
      end else begin
        digit_drive_reg <= 8'h00;
        seg_reg <= SEG_OFF;
        dp_reg <= 1'b0;
      end
    end
  end

  assign digit_drive = digit_drive_reg;
  assign seg_drive = seg_reg;
  assign dp_drive = dp_reg;
  assign least_digit_drive = digit_drive_reg[0];
  assign top_digit_drive = digit_drive_reg[DIGITS-1];

  // helper: cycles of current lit stretch
  logic [17:0] lit_cnt_reg;
  always_ff @(posedge clk) begin
    if (reset || digit_drive_reg == 8'h00) begin
      lit_cnt_reg <= 18'h0000;
    end else if (clk_en) begin
      lit_cnt_reg <= lit_cnt_reg + 18'h0001;
    end
  end

  a_slot_length_max:
  assert property (@(posedge clk) disable iff (reset)
    lit_cnt_reg <= slot_len)
  else $error("digit lit longer than one slot");

  a_gap_dark:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && phase_reg == LDS_GAP) |=> digit_drive_reg == 8'h00)
  else $error("digit driven during gap");

  a_one_digit:
  assert property (@(posedge clk) disable iff (reset)
    $onehot0(digit_drive_reg))
  else $error("more than one digit driven");

  a_off_blank:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && display_off) |=> (digit_drive == 8'h00 && !dp_drive))
  else $error("display off did not blank");

  a_test_eights:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && display_test && !display_off && phase_reg == LDS_SLOT)
    |=> (seg_drive == 7'h7F && dp_drive))
  else $error("test mode not showing eights");

  a_overflow_show:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && main_overflow && !display_off && !display_test
     && phase_reg == LDS_SLOT && cur_bcd == 4'h0)
    |=> seg_drive == 7'h3F)
  else $error("zero blanked during overflow");

  a_top_dp_ovf:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && any_overflow && !display_off
     && phase_reg == LDS_SLOT && digit_reg == TOP_INDEX)
    |=> (dp_drive && top_digit_drive))
  else $error("overflow point missing");

  a_leading_blank:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && phase_reg == LDS_SLOT && !display_off && !display_test
     && !main_overflow && digit_reg == TOP_INDEX && cur_bcd == 4'h0
     && dp_pos != TOP_INDEX) |=> seg_drive == 7'h00)
  else $error("leading zero not blanked");

  a_unit_dp_least:
  assert property (@(posedge clk) disable iff (reset)
    (clk_en && meas_mode == MODE_UNIT && phase_reg == LDS_SLOT
     && !display_off && digit_reg == 3'h0) |=> dp_drive)
  else $error("unit mode point not on least digit");

  // slot end is judged on the edge after it, so skip the reset edge
  a_slow_scan:
  assert property (@(posedge clk) disable iff (reset)
    (phase_reg == LDS_GAP && $past(phase_reg) == LDS_SLOT
     && $past(slow_timebase) && !$past(reset))
    |-> $past(count_reg) == 18'(SLOT_CNT * SLOW_DIV - 1))
  else $error("slow timebase slot ended early");
endmodule

// *** dv/lds_disp_model.sv ***
// Purpose: common cathode display as seen from the digit pins
// Assumes: high on a digit line lights that digit
// Notes: counts ghosting, a digit change with no dark cycle
`timescale 1ns/100ps
module lds_disp_model (
  input wire logic clk,
  input wire logic [7:0] digit_drive,
  output int ghosts
);
  logic [7:0] last_reg = 8'h00;
  logic swap;
  initial ghosts = 0;
  assign swap = digit_drive != last_reg && last_reg != 8'h00;
  always @(negedge clk) begin
    if (digit_drive != 8'h00 && swap) begin
      ghosts++;
    end
    last_reg <= digit_drive;
  end
endmodule

// *** dv/tb_top.sv ***
// Purpose: bench for the led digit scanner
// Assumes: short slot and gap counts
// Notes: only clk_en changes outside reset, so slots never mix data
`timescale 1ns/100ps
module tb_top;
  import lds_pkg::*;
  localparam int SL = 20;
  localparam int GP = 3;
  localparam logic [6:0] SEGS [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic clk, reset, clk_en, movf, aovf, test, off, slow, ld, td, dp, first;
  logic [31:0] vals, rnd;
  logic [3:0] mode;
  logic [1:0] rng;
  logic [7:0] dd;
  logic [6:0] seg;
  logic [42:0] sn;
  logic ce_s;
  logic [15:0] last_o;
  int mismatches, check_count, ghosts, idx, lit, dark, sl, gl;

  lds_scan #(.SLOT_CNT(SL), .GAP_CNT(GP)) i_dut (.clk(clk), .reset(reset),
    .clk_en(clk_en), .digit_values(vals), .meas_mode(mode),
    .range_sel(rng), .main_overflow(movf), .any_overflow(aovf),
    .display_test(test), .display_off(off), .slow_timebase(slow),
    .digit_drive(dd), .seg_drive(seg), .dp_drive(dp),
    .least_digit_drive(ld), .top_digit_drive(td));
  lds_disp_model i_disp (.clk(clk), .digit_drive(dd), .ghosts(ghosts));

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  function automatic logic [31:0] to_bcd(input logic [31:0] x);
    for (int i = 0; i < 8; i++) begin
      x[4*i +: 4] = x[4*i +: 4] % 4'ha;
    end
    return x;
  endfunction

  // s holds {values, mode, range, movf, aovf, test, off, slow}
  function automatic logic [7:0] exp_out(input int n, input logic [42:0] s);
    logic [3:0] d;
    logic dpb;
    int pos;
    d = s[11 + 4*n +: 4];
    pos = int'(s[6:5]) + int'(s[10:7] != MODE_RATIO);
    if (s[10:7] == MODE_UNIT) pos = 0;
    dpb = n == pos || (n == 7 && s[3]);
    if (s[2]) return 8'hff;
    if (!s[4] && n > pos && (s[42:11] >> (4 * n)) == 32'h0000_0000) begin
      return {7'h00, dpb};
    end
    return {d < 4'ha ? SEGS[d] : 7'h00, dpb};
  endfunction

  // outputs seen here answer the inputs of the previous cycle
  always @(negedge clk) begin
    sl = sn[0] ? 4 * SL : SL;
    gl = sn[0] ? 4 * GP : GP;
    if (reset) begin
      idx = 0;
      lit = 0;
      dark = 0;
      first = 1'b1;
    end else if (!ce_s) begin
      check({dd, seg, dp} === last_o, "not frozen");
    end else if (sn[1]) begin
      check(dd === 8'h00 && seg === 7'h00 && !dp, "display off");
    end else if (dd !== 8'h00) begin
      if (lit == 0) check(dark == gl + int'(first), "gap length");
      first = 1'b0;
      lit++;
      dark = 0;
      check(dd === 8'h01 << idx && ld === dd[0] && td === dd[7], "scan");
      check({seg, dp} === exp_out(idx, sn), "segments");
    end else begin
      if (lit > 0) check(lit == sl, "slot length");
      if (lit > 0) idx = (idx + 1) % 8;
      lit = 0;
      dark++;
      check(seg === 7'h00 && dp === 1'b0, "gap not dark");
    end
    sn = {vals, mode, rng, movf, aovf, test, off, slow};
    ce_s = clk_en;
    last_o = {dd, seg, dp};
  end

  task automatic scen(input logic [31:0] v, input logic [3:0] m,
    input logic [1:0] r, input logic [4:0] f, input int n, input logic g);
    @(posedge clk);
    reset <= 1'b1;
    clk_en <= 1'b1;
    vals <= v;
    mode <= m;
    rng <= r;
    {movf, aovf, test, off, slow} <= f;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rnd = lfsr(rnd);
      clk_en <= !g || rnd[9];
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(CLK_PERIOD_NS * 40000);
    mismatches++;
    end_of_test();
  end

  initial begin
    {reset, clk_en} = 2'b11;
    {vals, mode, rng, movf, aovf, test, off, slow} = 43'h000_0000_0000;
    sn = 43'h000_0000_0000;
    rnd = 32'h0001_38fa;
    for (logic [3:0] m = 4'h0; m < 4'h5; m++) begin
      for (logic [2:0] r = 3'h0; r < 3'h4; r++) begin
        rnd = lfsr(rnd);
        scen(to_bcd(rnd) >> (4 * rnd[30:28]), m, r[1:0],
          {rnd[5], rnd[6], 3'b000}, 400, rnd[7]);
      end
    end
    scen(32'h0000_0000, MODE_FREQ, 2'h2, 5'h00, 400, 1'b0);
    scen(32'h0000_0100, MODE_UNIT, 2'h0, 5'h10, 400, 1'b0);
    scen(32'h00ab_0c12, MODE_RATIO, 2'h3, 5'h08, 400, 1'b1);
    scen(32'h0000_0005, MODE_PERIOD, 2'h1, 5'h04, 400, 1'b0);
    scen(32'h1234_5678, MODE_INTERVAL, 2'h0, 5'h06, 400, 1'b0);
    scen(32'h0000_9876, MODE_FREQ, 2'h3, 5'h01, 1600, 1'b0);
    check(ghosts == 0, "ghosting");
    end_of_test();
  end
endmodule
